// [pkg/spdif_rx_regs.svh]
// Purpose: Register offsets, field positions and counts of the receive status and user buffers.
// Assumes: Byte-wide control port, one register per address.
// Notes: Definitions only.
`ifndef SPDIF_RX_REGS_SVH
`define SPDIF_RX_REGS_SVH
`define BUF_CFG_OFS 8'h10
`define CS_SWITCH_OFS 8'h11
`define INT_STAT_OFS 8'h12
`define INT_MASK_OFS 8'h13
`define UB_ADDR_OFS 8'h14
`define UB_DATA_OFS 8'h15
`define Q_STAT_OFS 8'h16
`define CS_FIRST_OFS 8'h20
`define CS_LAST_OFS 8'h37
`define Q_FIRST_OFS 8'h40
`define Q_LAST_OFS 8'h49
`define CFG_SIZE_BIT 0
`define CFG_MODE_LSB 1
`define CFG_FLAG_BIT 3
`define INT_CS_BIT 0
`define INT_UB_BIT 1
`define CS_LAST_FRAME 8'hbf
`define CS_CMP_BITS 40
`define UB_SMALL_LAST 7'h2f
`define UB_LARGE_LAST 7'h5f
`define IU_GAP_LAST 4'h8
`define Q_KEEP_LAST 7'h4f
`define Q_ALL_LAST 7'h5f
`define Q_CRC_POLY 16'h1021
`define CFG_RESET 4'h0
`define MASK_RESET 2'h0
`endif

// [pkg/spdif_rx_pkg.sv]
// Purpose: Types shared by the receive buffer logic.
// Assumes: Subframes arrive already decoded, one per valid pulse.
// Notes: Types only; numbers live in the register header.
package spdif_rx_pkg;
  // One decoded subframe as seen by the buffers.
  typedef struct packed {
    logic valid;
    logic chan_b;
    logic z_pre;
    logic c_bit;
    logic u_bit;
  } rx_subframe_t;
  // One access on the control port.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef enum logic [1:0] {UCFG_OFF, UCFG_RAW, UCFG_FMT, UCFG_RSVD} ucfg_t;
  typedef enum logic [1:0] {IU_HUNT, IU_BITS, IU_GAP} iu_state_t;
endpackage : spdif_rx_pkg

// [design/spdif_rx_buffers.sv]
// Purpose: Receive channel status and user bit buffers with host register access.
// Assumes: One clock; subframe and register requests synchronous to clk.
// Notes: Read data and interrupt request are registered.
`include "spdif_rx_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module spdif_rx_buffers
  import spdif_rx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire rx_subframe_t rx_sf,
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata_q,
  output logic irq_q
);

  logic [7:0] frame_q;
  logic [191:0] cs_acc_a_q, cs_acc_b_q, cs_buf_a_q, cs_buf_b_q;
  logic [3:0] cfg_q;
  logic cs_switch_q;
  logic [1:0] int_stat_q, int_mask_q;
  logic crc_fail_q;
  logic [6:0] uaddr_q;
  logic [7:0] fill_mem [0:95];
  logic [7:0] read_mem [0:95];
  logic [6:0] wptr_q, wptr_d;
  logic [7:0] sh_q, sh_d;
  logic [2:0] bit_q, bit_d;
  logic [3:0] zc_q, zc_d;
  logic wait_z_q, wait_z_d;
  logic commit_q;
  iu_state_t iu_q, iu_d;
  logic [6:0] q_cnt_q;
  logic [79:0] q_sr_q, q_buf_q;
  logic [15:0] q_tail_q, crc_q;
  logic wr_en, commit, iu_done;
  logic [7:0] wr_byte;

  // Channel status block tracking; a Z preamble restarts the frame count.
  wire sf_a = rx_sf.valid & ~rx_sf.chan_b;
  wire sf_b = rx_sf.valid & rx_sf.chan_b;
  wire [7:0] fa_idx = (rx_sf.z_pre || frame_q == `CS_LAST_FRAME) ? 8'h00 : frame_q + 8'h01;
  wire cs_done = sf_b & (frame_q == `CS_LAST_FRAME);
  wire [191:0] cs_new_b = {rx_sf.c_bit, cs_acc_b_q[190:0]};
  wire cs_changed = (cs_acc_a_q[`CS_CMP_BITS-1:0] != cs_buf_a_q[`CS_CMP_BITS-1:0]) |
                    (cs_new_b[`CS_CMP_BITS-1:0] != cs_buf_b_q[`CS_CMP_BITS-1:0]);
  wire cs_evt = cs_done & (cfg_q[`CFG_FLAG_BIT] ? cs_changed : 1'b1);

  // User buffer mode resolution; pro bit and byte 1 bits 7-4 come from the channel A copy.
  wire pro = cs_buf_a_q[0];
  wire [3:0] auto_code = cs_buf_a_q[15:12];
  wire [1:0] ucfg = cfg_q[`CFG_MODE_LSB +: 2];
  wire is_auto = (ucfg == UCFG_FMT) & pro;
  wire auto_raw = auto_code == 4'h4 || auto_code == 4'hc || auto_code == 4'h8;
  wire raw_mode = (ucfg == UCFG_RAW) | (is_auto & auto_raw);
  wire iu_mode = (ucfg == UCFG_FMT) & ~pro;
  wire eff_size = (is_auto && auto_code == 4'h8) ? 1'b0 : cfg_q[`CFG_SIZE_BIT];
  wire [6:0] ub_last = eff_size ? `UB_LARGE_LAST : `UB_SMALL_LAST;

  // Raw user bits start only at a Z preamble so every block is aligned.
  wire raw_start = wait_z_q & sf_a & rx_sf.z_pre;
  wire raw_take = rx_sf.valid & raw_mode & (~wait_z_q | raw_start);
  wire [7:0] shifted = {sh_q[6:0], rx_sf.u_bit};
  wire iu_in = rx_sf.valid & iu_mode;
  wire q_bit = sh_q[5];

  // Register access decode.
  wire rd_int = reg_req.rd && reg_req.addr == `INT_STAT_OFS;
  wire rd_q = reg_req.rd && reg_req.addr == `Q_STAT_OFS;
  wire rd_ub = reg_req.rd && reg_req.addr == `UB_DATA_OFS;
  wire wr_cfg = reg_req.wr && reg_req.addr == `BUF_CFG_OFS;
  wire wr_sw = reg_req.wr && reg_req.addr == `CS_SWITCH_OFS;
  wire wr_mask = reg_req.wr && reg_req.addr == `INT_MASK_OFS;
  wire wr_ua = reg_req.wr && reg_req.addr == `UB_ADDR_OFS;
  wire in_cs = reg_req.addr >= `CS_FIRST_OFS && reg_req.addr <= `CS_LAST_OFS;
  wire in_qb = reg_req.addr >= `Q_FIRST_OFS && reg_req.addr <= `Q_LAST_OFS;
  wire [7:0] cs_idx = reg_req.addr - `CS_FIRST_OFS;
  wire [7:0] qb_idx = reg_req.addr - `Q_FIRST_OFS;
  wire [191:0] cs_view = cs_switch_q ? cs_buf_b_q : cs_buf_a_q;
  wire [7:0] cs_byte = cs_view[{cs_idx[4:0], 3'b000} +: 8];
  wire [79:0] q_view = q_buf_q << {qb_idx[3:0], 3'b000};
  wire [7:0] ua_next = (uaddr_q == ub_last) ? 8'h00 : {1'b0, uaddr_q} + 8'h01;
  wire [1:0] int_set = {commit_q & int_mask_q[`INT_UB_BIT], cs_evt};

  // Shared fill path: raw bytes or stored units go into the first buffer.
  always_comb begin
    wptr_d = wptr_q;
    sh_d = sh_q;
    bit_d = bit_q;
    zc_d = zc_q;
    wait_z_d = wait_z_q;
    iu_d = iu_q;
    wr_en = 1'b0;
    wr_byte = shifted;
    commit = 1'b0;
    iu_done = 1'b0;
    if (raw_mode) begin
      iu_d = IU_HUNT;
      if (raw_take) begin
        wait_z_d = 1'b0;
        sh_d = shifted;
        bit_d = raw_start ? 3'h1 : bit_q + 3'h1;
        if (raw_start) begin
          wptr_d = 7'h00;
          sh_d = {7'h00, rx_sf.u_bit};
        end else if (bit_q == 3'h7) begin
          wr_en = 1'b1;
          wptr_d = wptr_q + 7'h01;
          if (wptr_q == ub_last) begin
            commit = 1'b1;
            wptr_d = 7'h00;
            wait_z_d = 1'b1;
          end
        end
      end
    end else if (iu_mode) begin
      wait_z_d = 1'b1;
      if (iu_in) begin
        case (iu_q)
          IU_HUNT: begin
            if (rx_sf.u_bit) begin
              iu_d = IU_BITS;
              sh_d = 8'h01;
              bit_d = 3'h0;
            end
          end
          IU_BITS: begin
            sh_d = shifted;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h6) begin
              wr_en = wptr_q <= `UB_LARGE_LAST;
              wptr_d = wr_en ? wptr_q + 7'h01 : wptr_q;
              iu_done = 1'b1;
              iu_d = IU_GAP;
              zc_d = 4'h0;
            end
          end
          IU_GAP: begin
            if (rx_sf.u_bit) begin
              iu_d = IU_BITS;
              sh_d = 8'h01;
              bit_d = 3'h0;
            end else if (zc_q == `IU_GAP_LAST) begin
              commit = 1'b1;
              wptr_d = 7'h00;
              iu_d = IU_HUNT;
            end else begin
              zc_d = zc_q + 4'h1;
            end
          end
          default: iu_d = IU_HUNT;
        endcase
      end
    end else begin
      wait_z_d = 1'b1;
      iu_d = IU_HUNT;
      wptr_d = 7'h00;
    end
  end

  // Channel status accumulation and block copy.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      frame_q <= `CS_LAST_FRAME;
      cs_acc_a_q <= '0;
      cs_acc_b_q <= '0;
      cs_buf_a_q <= '0;
      cs_buf_b_q <= '0;
    end else begin
      if (sf_a) begin
        frame_q <= fa_idx;
        cs_acc_a_q[fa_idx] <= rx_sf.c_bit;
      end
      if (sf_b) begin
        cs_acc_b_q[frame_q] <= rx_sf.c_bit;
      end
      if (cs_done) begin
        cs_buf_a_q <= cs_acc_a_q;
        cs_buf_b_q <= cs_new_b;
      end
    end
  end

  // Fill engine state.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr_q <= 7'h00;
      sh_q <= 8'h00;
      bit_q <= 3'h0;
      zc_q <= 4'h0;
      wait_z_q <= 1'b1;
      iu_q <= IU_HUNT;
      commit_q <= 1'b0;
    end else begin
      wptr_q <= wptr_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      zc_q <= zc_d;
      wait_z_q <= wait_z_d;
      iu_q <= iu_d;
      commit_q <= commit;
    end
  end

  // Buffers carry no reset; the copy waits a cycle so the final byte is in place.
  always_ff @(posedge clk) begin
    if (wr_en) begin
      fill_mem[wptr_q] <= wr_byte;
    end
    if (commit_q) begin
      for (int i = 0; i < 96; i++) begin
        read_mem[i] <= fill_mem[i];
      end
    end
  end

  // Q subcode capture and CRC check over the unit stream.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_cnt_q <= 7'h00;
      q_sr_q <= '0;
      q_buf_q <= '0;
      q_tail_q <= 16'h0000;
      crc_q <= 16'h0000;
      crc_fail_q <= 1'b0;
    end else begin
      if (commit & iu_mode) begin
        q_cnt_q <= 7'h00;
        crc_q <= 16'h0000;
      end else if (iu_done && q_cnt_q <= `Q_ALL_LAST) begin
        q_cnt_q <= q_cnt_q + 7'h01;
        if (q_cnt_q <= `Q_KEEP_LAST) begin
          q_sr_q <= {q_sr_q[78:0], q_bit};
          crc_q <= {crc_q[14:0], 1'b0} ^ ((crc_q[15] ^ q_bit) ? `Q_CRC_POLY : 16'h0000);
        end else begin
          q_tail_q <= {q_tail_q[14:0], q_bit};
        end
        if (q_cnt_q == `Q_ALL_LAST) begin
          q_buf_q <= q_sr_q;
        end
      end
      if (iu_done && q_cnt_q == `Q_ALL_LAST && ~crc_q != {q_tail_q[14:0], q_bit}) begin
        crc_fail_q <= 1'b1;
      end else if (rd_q) begin
        crc_fail_q <= 1'b0;
      end
    end
  end

  // Host registers; a flag raised in the cycle of its read stays set.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= `CFG_RESET;
      cs_switch_q <= 1'b0;
      int_mask_q <= `MASK_RESET;
      int_stat_q <= 2'h0;
      uaddr_q <= 7'h00;
      irq_q <= 1'b0;
    end else begin
      if (wr_cfg) cfg_q <= reg_req.wdata[3:0];
      if (wr_sw) cs_switch_q <= reg_req.wdata[0];
      if (wr_mask) int_mask_q <= reg_req.wdata[1:0];
      int_stat_q <= int_set | (rd_int ? 2'h0 : int_stat_q);
      irq_q <= |(int_stat_q & int_mask_q);
      if (wr_ua) begin
        uaddr_q <= reg_req.wdata[6:0];
      end else if (rd_ub) begin
        uaddr_q <= ua_next[6:0];
      end
    end
  end

  // Read data selection, registered on the read strobe.
  logic [7:0] rd_mux;
  always_comb begin
    if (reg_req.addr == `BUF_CFG_OFS) rd_mux = {4'h0, cfg_q};
    else if (reg_req.addr == `CS_SWITCH_OFS) rd_mux = {7'h00, cs_switch_q};
    else if (reg_req.addr == `INT_STAT_OFS) rd_mux = {6'h00, int_stat_q};
    else if (reg_req.addr == `INT_MASK_OFS) rd_mux = {6'h00, int_mask_q};
    else if (reg_req.addr == `UB_ADDR_OFS) rd_mux = {1'b0, uaddr_q};
    else if (reg_req.addr == `UB_DATA_OFS) rd_mux = read_mem[uaddr_q];
    else if (reg_req.addr == `Q_STAT_OFS) rd_mux = {7'h00, crc_fail_q};
    else if (in_cs) rd_mux = cs_byte;
    else if (in_qb) rd_mux = q_view[79:72];
    else rd_mux = 8'h00;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata_q <= rd_mux;
    end
  end

endmodule : spdif_rx_buffers
`default_nettype wire

// [bench/spdif_src_model.sv]
// Purpose: Source of decoded subframes, A then B, one every four clocks.
// Assumes: Patterns stay fixed, so every block repeats the same bits.
// Notes: Fields are scrambled between subframes so stale bits never pass.
`timescale 1ns/1ps
`default_nettype none
module spdif_src_model
  import spdif_rx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [191:0] cs_a,
  input wire logic [191:0] cs_b,
  input wire logic [383:0] ub,
  output var rx_subframe_t rx_sf
);
  logic [10:0] cnt_q;
  // Frame in [10:3], channel in [2], spacing phase in [1:0]; Z marks frame 0 of channel A.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 11'h000;
      rx_sf <= '0;
    end else begin
      cnt_q <= (cnt_q == 11'h5ff) ? 11'h000 : cnt_q + 11'h001;
      if (cnt_q[1:0] == 2'h0) begin
        rx_sf <= '{valid: 1'b1, chan_b: cnt_q[2], z_pre: cnt_q[10:2] == 9'h000,
                   c_bit: cnt_q[2] ? cs_b[cnt_q[10:3]] : cs_a[cnt_q[10:3]], u_bit: ub[9'd383 - cnt_q[10:2]]};
      end else begin
        rx_sf <= {1'b0, ~rx_sf[3:0]};
      end
    end
  end
endmodule : spdif_src_model
`default_nettype wire

// [bench/spdif_rx_properties.sv]
// Purpose: Port checks of the receive buffer block.
// Assumes: Mask register is mirrored from control port writes.
// Notes: Bound to the block below.
`include "spdif_rx_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module spdif_rx_props
  import spdif_rx_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire rx_subframe_t rx_sf,
  input wire reg_req_t reg_req,
  input wire logic [7:0] reg_rdata_q,
  input wire logic irq_q
);
  logic [1:0] mask_q;
  wire logic [7:0] wdata_w = reg_req.wdata;
  // Mirror of the mask, so interrupt timing can be judged without the body.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_q <= 2'h0;
    end else if (reg_req.wr && reg_req.addr == `INT_MASK_OFS) begin
      mask_q <= wdata_w[1:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Two reads with no subframe near them, so no new flag can slip in.
  sequence s_quiet_rd(a);
    !rx_sf.valid ##1 (reg_req.rd && reg_req.addr == a && !rx_sf.valid) [*2];
  endsequence
  sequence s_wr_rd(a);
    (reg_req.wr && reg_req.addr == a) ##1 (reg_req.rd && reg_req.addr == a);
  endsequence
  property p_hold; !reg_req.rd |=> $stable(reg_rdata_q); endproperty
  property p_unmapped; reg_req.rd && (reg_req.addr == 8'h38 || reg_req.addr == 8'h1f) |=> reg_rdata_q == 8'h00;
  endproperty
  property p_stat_clear; s_quiet_rd(`INT_STAT_OFS) |=> reg_rdata_q == 8'h00; endproperty
  property p_crc_clear; s_quiet_rd(`Q_STAT_OFS) |=> reg_rdata_q[0] == 1'b0; endproperty
  property p_irq; reg_req.rd && reg_req.addr == `INT_STAT_OFS |=> irq_q == |(reg_rdata_q[1:0] & $past(mask_q));
  endproperty
  property p_irq_off; $past(mask_q) == 2'h0 |-> !irq_q; endproperty
  property p_cfg_rb; s_wr_rd(`BUF_CFG_OFS) |=> (reg_rdata_q & 8'h0f) == ($past(wdata_w, 2) & 8'h0f); endproperty
  property p_sel_rb; s_wr_rd(`CS_SWITCH_OFS) |=> reg_rdata_q[0] == $past(wdata_w[0], 2); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_stat_clear: assert property (p_stat_clear) else $error("status not cleared by read");
  a_crc_clear: assert property (p_crc_clear) else $error("crc flag not cleared by read");
  a_irq: assert property (p_irq) else $error("irq differs from masked status");
  a_irq_off: assert property (p_irq_off) else $error("irq with all masks clear");
  a_cfg_rb: assert property (p_cfg_rb) else $error("config readback wrong");
  a_sel_rb: assert property (p_sel_rb) else $error("channel select readback wrong");
endmodule : spdif_rx_props
bind spdif_rx_buffers spdif_rx_props i_props (.clk(clk), .rst_b(rst_b), .rx_sf(rx_sf), .reg_req(reg_req),
  .reg_rdata_q(reg_rdata_q), .irq_q(irq_q));
`default_nettype wire

// [bench/tb_top.sv]
// Purpose: Self-checking bench of the receive buffer block.
// Assumes: Source repeats one pattern, so any committed block is predictable.
// Notes: Expected read bytes are queued with a care mask and compared as data appears.
`include "spdif_rx_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import spdif_rx_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  rx_subframe_t sf;
  reg_req_t req = '0;
  logic [7:0] rdata;
  logic irq;
  logic [191:0] cs_a;
  logic [191:0] cs_b;
  logic [383:0] ub;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic pend = 1'b0;
  int n_errors = 0;
  int n_checks = 0;
  // Clock of 20 ns period.
  always #10 clk = ~clk;
  spdif_rx_buffers i_dut (.clk(clk), .rst_b(rst_b), .rx_sf(sf), .reg_req(req), .reg_rdata_q(rdata), .irq_q(irq));
  spdif_src_model i_src (.clk(clk), .rst_b(rst_b), .cs_a(cs_a), .cs_b(cs_b), .ub(ub), .rx_sf(sf));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic results();
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m = 8'hff);
    @(posedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    exp_q.push_back({m, x & m});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
  endtask : wr
  task automatic idle();
    @(posedge clk);
    req <= '0;
  endtask : idle
  // Idles long enough for an old irq to drop, then waits for a new one.
  task automatic wait_irq();
    int i;
    repeat (3) idle();
    // A 768-bit fill may first wait a whole block for its Z start, so the limit covers three blocks.
    for (i = 0; i < 6000 && irq !== 1'b1; i++) @(posedge clk);
    chk("irq", {7'h00, irq}, 8'h01);
  endtask : wait_irq
  task automatic wait_sf();
    idle();
    @(posedge clk iff sf.valid);
  endtask : wait_sf
  // Read data appears one edge after the read is taken; judged at the falling edge.
  always @(negedge clk) begin
    if (pend) begin
      e = exp_q.pop_front();
      chk("rdata", rdata & e[15:8], e[7:0]);
    end
    pend = req.rd;
  end
  // Cuts a hang short well beyond the longest expected run.
  initial begin
    #800000;
    n_errors++;
    results();
  end
  initial begin : main
    int k;
    k = $urandom(44);
    for (k = 0; k < 12; k++) ub[k*32 +: 32] = $urandom();
    for (k = 0; k < 6; k++) cs_a[k*32 +: 32] = $urandom();
    for (k = 0; k < 6; k++) cs_b[k*32 +: 32] = $urandom();
    // Consumer stream, so the formatted mode takes the unit path.
    cs_a[0] = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(`BUF_CFG_OFS, 8'h00);
    rd(`INT_MASK_OFS, 8'h00);
    rd(8'h38, 8'h00);
    rd(8'h1f, 8'h00);
    wr(`INT_MASK_OFS, 8'h01);
    wait_irq();
    wait_sf();
    rd(`INT_STAT_OFS, 8'h01);
    rd(`INT_STAT_OFS, 8'h00);
    wait_sf();
    rd(`Q_STAT_OFS, 8'h00, 8'h01);
    rd(`Q_STAT_OFS, 8'h00, 8'h01);
    for (k = 0; k < 24; k++) rd(`CS_FIRST_OFS + k[7:0], cs_a[8*k +: 8]);
    wr(`CS_SWITCH_OFS, 8'h01);
    rd(`CS_SWITCH_OFS, 8'h01, 8'h01);
    for (k = 0; k < 24; k++) rd(`CS_FIRST_OFS + k[7:0], cs_b[8*k +: 8]);
    // Flag only on change: the repeated pattern must stay quiet.
    wr(`BUF_CFG_OFS, 8'h08);
    rd(`BUF_CFG_OFS, 8'h08, 8'h0f);
    rd(`INT_STAT_OFS, 8'h00, 8'h00);
    repeat (3200) idle();
    rd(`INT_STAT_OFS, 8'h00, 8'h01);
    // Raw user bits, 384-bit buffer, read back through the indirect pair.
    wr(`INT_MASK_OFS, 8'h02);
    wr(`BUF_CFG_OFS, 8'h02);
    rd(`BUF_CFG_OFS, 8'h02, 8'h0f);
    rd(`INT_STAT_OFS, 8'h00, 8'h00);
    wait_irq();
    rd(`INT_STAT_OFS, 8'h02, 8'h02);
    wr(`UB_ADDR_OFS, 8'h00);
    for (k = 0; k < 49; k++) rd(`UB_DATA_OFS, ub[383 - 8*(k%48) -: 8]);
    wr(`UB_ADDR_OFS, 8'h05);
    rd(`UB_DATA_OFS, ub[343 -: 8]);
    // 768-bit buffer holds two copies of the block and wraps after byte 95.
    wr(`BUF_CFG_OFS, 8'h03);
    rd(`INT_STAT_OFS, 8'h00, 8'h00);
    wait_irq();
    wr(`UB_ADDR_OFS, 8'h5e);
    for (k = 94; k < 97; k++) rd(`UB_DATA_OFS, ub[383 - 8*(k%48) -: 8]);
    // Formatted consumer data: four units, one stuffed zero after each, then a long zero run.
    ub <= {8'hc5, 1'b0, 8'h9a, 1'b0, 8'hff, 1'b0, 8'h81, 1'b0, 348'h0};
    wr(`BUF_CFG_OFS, 8'h04);
    rd(`INT_STAT_OFS, 8'h00, 8'h00);
    // The first message after the switch may be cut, so only the second one is judged.
    wait_irq();
    rd(`INT_STAT_OFS, 8'h02, 8'h02);
    wait_irq();
    wr(`UB_ADDR_OFS, 8'h00);
    rd(`UB_DATA_OFS, 8'hc5);
    rd(`UB_DATA_OFS, 8'h9a);
    rd(`UB_DATA_OFS, 8'hff);
    rd(`UB_DATA_OFS, 8'h81);
    repeat (3) idle();
    results();
  end
endmodule : tb_top
`default_nettype wire
